/* rtl/cdf_pkg.sv */
// Behaviour
// - Integrate only while the integration window is high; digitise after it closes.
// - After all conversions, discharge every integrator before the next window.
// - Each channel yields a fine-range word and a coarse-range word.
// - Two 12-bit converters, eight channels each, taken in channel pairs.
// - Sliding scale adds a known offset, then subtracts it before comparison.
// - With sliding scale, corrected codes above 3840 are invalid.
// - Results at or above the channel low threshold go to the data memory.
// - Sixteen threshold entries at 0x1080 to 0x10bf, writable, default zero.
// - Scale control 0 compares result bits 11:4 with the threshold.
// - Scale control 1: below when bits 8:1 under threshold and 11:9 zero.
// - Below-threshold results are dropped when keep-below control is 0.
// - With keep-below set, below-threshold results are stored with bit 13 set.
// - A channel whose discard bit is set is never stored.
// - No reset alters the threshold memory.
// - By default overflowed results are detected and not stored.
// - With keep-overflow set, overflowed results are stored with bit 12 set.
package cdf_pkg;

    // Channel and word geometry.
    localparam int unsigned NUM_CH      = 16;
    localparam int unsigned CH_W        = 4;
    localparam int unsigned PAIR_W      = 3;
    localparam int unsigned RES_W       = 12;
    localparam int unsigned WORD_W      = 16;
    localparam int unsigned ADDR_W      = 16;
    localparam int unsigned OFS_W       = 8;

    // Threshold memory window; one 32-bit slot per channel.
    localparam logic [ADDR_W-1:0] THR_BASE   = 16'h1080;
    localparam logic [ADDR_W-1:0] THR_LAST   = 16'h10bf;
    localparam int unsigned       THR_IDX_LSB = 2;
    localparam logic [WORD_W-1:0] THR_RESET  = 16'h0000;

    // Threshold entry fields.
    localparam int unsigned THR_LVL_LSB  = 0;
    localparam int unsigned THR_LVL_W    = 8;
    localparam int unsigned THR_KILL_BIT = 8;
    localparam logic [WORD_W-1:0] THR_USED_MASK = 16'h01ff;

    // Stored data word fields.
    localparam int unsigned WORD_OVF_BIT   = 12;
    localparam int unsigned WORD_BELOW_BIT = 13;
    localparam int unsigned WORD_RANGE_BIT = 14;

    // Highest valid corrected code under sliding scale.
    localparam logic [RES_W-1:0] SLIDE_MAX = 12'hf00;

    // Integrator discharge time, rounded up to whole cycles.
    localparam int unsigned CLK_PERIOD_NS     = 50;
    localparam int unsigned DISCHARGE_TIME_NS = 500;
    localparam int unsigned DISCHARGE_CYC     =
        (DISCHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DCNT_W = 8;

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_INTEG,
        ST_REQ,
        ST_WAIT,
        ST_EMIT_A,
        ST_EMIT_B,
        ST_DISCHARGE
    } cdf_state_e;

    // One accepted result on its way to the data memory.
    typedef struct packed {
        logic [CH_W-1:0]   chan;
        logic [WORD_W-1:0] word;
    } cdf_result_s;

    localparam int unsigned RESULT_W = $bits(cdf_result_s);

endpackage : cdf_pkg

/* rtl/cdf_skid_buf.sv */
`timescale 1ns/1ps
`default_nettype none
// Two-entry buffer: an output stage plus one skid slot. Outputs are flops, except ready, the inverted skid flag.
module cdf_skid_buf #(
    parameter int unsigned W = 8
) (
    // Clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         reset_i,
    // Filling side
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // Draining side
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);

    logic         skid_valid_ff;
    logic [W-1:0] skid_data_ff;
    logic         take;
    logic         drain;

    // Ready is just the skid slot being free, so it never depends on the sink.
    assign in_ready_o = ~skid_valid_ff;
    assign take       = in_valid_i & ~skid_valid_ff;
    assign drain      = out_ready_i | ~out_valid_o;

    // Output stage refills from the skid slot first to keep word order.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            out_valid_o <= 1'b0;
            out_data_o  <= '0;
        end else if (drain) begin
            if (skid_valid_ff) begin
                out_valid_o <= 1'b1;
                out_data_o  <= skid_data_ff;
            end else if (take) begin
                out_valid_o <= 1'b1;
                out_data_o  <= in_data_i;
            end else begin
                out_valid_o <= 1'b0;
            end
        end
    end

    // Skid slot catches the word that arrives while the sink stalls.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            skid_valid_ff <= 1'b0;
            skid_data_ff  <= '0;
        end else if (drain) begin
            skid_valid_ff <= 1'b0;
        end else if (take) begin
            skid_valid_ff <= 1'b1;
            skid_data_ff  <= in_data_i;
        end
    end

endmodule : cdf_skid_buf
`default_nettype wire

/* rtl/cdf_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Acceptance stage of the sixteen-channel charge digitiser.
module cdf_top
    import cdf_pkg::*;
(
    // Clock and reset
    input  wire logic                clk_sys_i,
    input  wire logic                reset_i,
    // Integration window and front-end switches
    input  wire logic                gate_i,
    output logic                     integrate_switch_o,
    output logic                     discharge_switch_o,
    output logic                     busy_o,
    // Shared converters
    output logic                     conv_start_o,
    output logic [PAIR_W-1:0]        conv_pair_o,
    output logic                     conv_range_o,
    input  wire logic                conv_done_i,
    input  wire logic [RES_W-1:0]    conv_a_data_i,
    input  wire logic                conv_a_ovf_i,
    input  wire logic [RES_W-1:0]    conv_b_data_i,
    input  wire logic                conv_b_ovf_i,
    // Sliding scale
    input  wire logic                slide_en_i,
    output logic                     slide_add_o,
    output logic [OFS_W-1:0]         slide_offset_o,
    // Acceptance controls
    input  wire logic                thr_scale_i,
    input  wire logic                keep_below_i,
    input  wire logic                keep_ovf_i,
    // Threshold memory port
    input  wire logic [ADDR_W-1:0]   reg_addr_i,
    input  wire logic                reg_wr_i,
    input  wire logic [WORD_W-1:0]   reg_wdata_i,
    input  wire logic                reg_rd_i,
    output logic [WORD_W-1:0]        reg_rdata_o,
    output logic                     reg_rvalid_o,
    // Data memory write side
    output logic                     mem_wr_valid_o,
    input  wire logic                mem_wr_ready_i,
    output logic [CH_W-1:0]          mem_wr_chan_o,
    output logic [WORD_W-1:0]        mem_wr_data_o
);

    // Sequencer state and counters.
    cdf_state_e          state_ff;
    cdf_state_e          nxt_state;
    logic [PAIR_W:0]     step_ff;
    logic [DCNT_W-1:0]   dcnt_ff;
    logic                last_step;
    logic                dcnt_done;

    // Latched converter results for the current pair.
    logic [RES_W-1:0]    lat_a_ff;
    logic [RES_W-1:0]    lat_b_ff;
    logic                lat_a_ovf_ff;
    logic                lat_b_ovf_ff;

    // Threshold memory; deliberately outside every reset.
    logic [WORD_W-1:0]   thr_mem_ff [NUM_CH] = '{default: THR_RESET};
    logic                thr_hit;
    logic [CH_W-1:0]     thr_idx;

    // Evaluation of the result now being emitted.
    logic                sel_b;
    logic [CH_W-1:0]     cur_chan;
    logic [RES_W-1:0]    cur_raw;
    logic                cur_ovf_in;
    logic [WORD_W-1:0]   cur_thr;
    logic [RES_W:0]      slide_diff;
    logic [RES_W-1:0]    cur_val;
    logic                cur_bad;
    logic                cur_ovf;
    logic                cur_below;
    logic                cur_kill;
    logic                cur_keep;
    logic                emitting;
    logic                push;
    cdf_result_s         push_res;
    cdf_result_s         out_res;
    logic                buf_in_ready;

    assign last_step = (step_ff == {(PAIR_W + 1){1'b1}});
    assign dcnt_done = (dcnt_ff == DCNT_W'(DISCHARGE_CYC - 1));

    // Threshold memory address decode.
    assign thr_hit = (reg_addr_i >= THR_BASE) && (reg_addr_i <= THR_LAST);
    assign thr_idx = reg_addr_i[THR_IDX_LSB +: CH_W];

    // Sequencer: the window, then sixteen converter steps, then discharge.
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (gate_i) begin
                    nxt_state = ST_INTEG;
                end
            end
            ST_INTEG: begin
                if (!gate_i) begin
                    nxt_state = ST_REQ;
                end
            end
            ST_REQ: begin
                nxt_state = ST_WAIT;
            end
            ST_WAIT: begin
                if (conv_done_i) begin
                    nxt_state = ST_EMIT_A;
                end
            end
            ST_EMIT_A: begin
                if (!cur_keep || buf_in_ready) begin
                    nxt_state = ST_EMIT_B;
                end
            end
            ST_EMIT_B: begin
                if (!cur_keep || buf_in_ready) begin
                    nxt_state = last_step ? ST_DISCHARGE : ST_REQ;
                end
            end
            ST_DISCHARGE: begin
                if (dcnt_done) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Step counter: low bits pick the channel pair, top bit the range.
    // Fine range goes first for all pairs, then coarse range.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            step_ff <= '0;
        end else if (state_ff == ST_INTEG) begin
            step_ff <= '0;
        end else if (state_ff == ST_EMIT_B && nxt_state != ST_EMIT_B) begin
            step_ff <= step_ff + 1'b1;
        end
    end

    // Discharge timer; the switch stays closed for the full settling time.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            dcnt_ff <= '0;
        end else if (state_ff == ST_DISCHARGE) begin
            dcnt_ff <= dcnt_ff + 1'b1;
        end else begin
            dcnt_ff <= '0;
        end
    end

    // Front-end switches are registered from the next state, so they change on the same edge as the state.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            integrate_switch_o <= 1'b0;
            discharge_switch_o <= 1'b0;
            busy_o             <= 1'b0;
        end else begin
            integrate_switch_o <= (nxt_state == ST_INTEG);
            discharge_switch_o <= (nxt_state == ST_DISCHARGE);
            busy_o             <= (nxt_state != ST_IDLE);
        end
    end

    // Converter request: one start pulse per step, both converters together.
    // Converter A serves channels 0-7, converter B channels 8-15.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            conv_start_o <= 1'b0;
            conv_pair_o  <= '0;
            conv_range_o <= 1'b0;
        end else begin
            conv_start_o <= (state_ff == ST_REQ);
            if (state_ff == ST_REQ) begin
                conv_pair_o  <= step_ff[PAIR_W-1:0];
                conv_range_o <= step_ff[PAIR_W];
            end
        end
    end

    // Capture both converter words when they report done.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            lat_a_ff     <= '0;
            lat_b_ff     <= '0;
            lat_a_ovf_ff <= 1'b0;
            lat_b_ovf_ff <= 1'b0;
        end else if (state_ff == ST_WAIT && conv_done_i) begin
            lat_a_ff     <= conv_a_data_i;
            lat_b_ff     <= conv_b_data_i;
            lat_a_ovf_ff <= conv_a_ovf_i;
            lat_b_ovf_ff <= conv_b_ovf_i;
        end
    end

    // Sliding-scale offset: fixed over one event, stepped after discharge.
    // The enable is sampled at the window so an event is never half-corrected.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            slide_add_o    <= 1'b0;
            slide_offset_o <= '0;
        end else begin
            if (state_ff == ST_IDLE && gate_i) begin
                slide_add_o <= slide_en_i;
            end
            if (state_ff == ST_DISCHARGE && dcnt_done && slide_add_o) begin
                slide_offset_o <= slide_offset_o + 1'b1;
            end
        end
    end

    // Pick the word now under evaluation.
    assign emitting = (state_ff == ST_EMIT_A) || (state_ff == ST_EMIT_B);
    assign sel_b    = (state_ff == ST_EMIT_B);
    assign cur_chan = {sel_b, step_ff[PAIR_W-1:0]};
    assign cur_raw  = sel_b ? lat_b_ff : lat_a_ff;
    assign cur_ovf_in = sel_b ? lat_b_ovf_ff : lat_a_ovf_ff;
    assign cur_thr  = thr_mem_ff[cur_chan];
    assign cur_kill = cur_thr[THR_KILL_BIT];

    // Remove the added offset; a borrow or a code above the valid span is bad.
    assign slide_diff = {1'b0, cur_raw} - {{(RES_W + 1 - OFS_W){1'b0}}, slide_offset_o};

    always_comb begin
        if (slide_add_o) begin
            cur_val = slide_diff[RES_W-1:0];
            cur_bad = slide_diff[RES_W] || (slide_diff[RES_W-1:0] > SLIDE_MAX);
        end else begin
            cur_val = cur_raw;
            cur_bad = 1'b0;
        end
    end

    // An invalid sliding-scale code is handled like a converter overflow.
    assign cur_ovf = cur_ovf_in | cur_bad;

    // Threshold comparison in either scale.
    always_comb begin
        if (thr_scale_i) begin
            cur_below = (cur_val[8:1] < cur_thr[THR_LVL_LSB +: THR_LVL_W]) &&
                        (cur_val[11:9] == 3'h0);
        end else begin
            cur_below = (cur_val[11:4] < cur_thr[THR_LVL_LSB +: THR_LVL_W]);
        end
    end

    // Store decision: discard bit first, then overflow, then threshold.
    always_comb begin
        cur_keep = 1'b1;
        if (cur_kill) begin
            cur_keep = 1'b0;
        end else if (cur_ovf && !keep_ovf_i) begin
            cur_keep = 1'b0;
        end else if (cur_below && !keep_below_i) begin
            cur_keep = 1'b0;
        end
    end

    // Build the stored word with its flag bits.
    always_comb begin
        push_res.chan = cur_chan;
        push_res.word = {{(WORD_W - RES_W){1'b0}}, cur_val};
        push_res.word[WORD_OVF_BIT]   = cur_ovf;
        push_res.word[WORD_BELOW_BIT] = cur_below;
        push_res.word[WORD_RANGE_BIT] = step_ff[PAIR_W];
    end

    // The sequencer waits in an emit state until the buffer takes the word.
    assign push = emitting && cur_keep;

    cdf_skid_buf #(
        .W (RESULT_W)
    ) u_buf (
        .clk_sys_i   (clk_sys_i),
        .reset_i     (reset_i),
        .in_valid_i  (push),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (push_res),
        .out_valid_o (mem_wr_valid_o),
        .out_ready_i (mem_wr_ready_i),
        .out_data_o  (out_res)
    );

    assign mem_wr_chan_o = out_res.chan;
    assign mem_wr_data_o = out_res.word;

    // Threshold memory writes; no reset branch so contents survive any reset.
    always_ff @(posedge clk_sys_i) begin
        if (reg_wr_i && thr_hit) begin
            thr_mem_ff[thr_idx] <= reg_wdata_i & THR_USED_MASK;
        end
    end

    // Register reads answer one cycle later; unmapped addresses read zero.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            reg_rdata_o  <= '0;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= thr_hit ? thr_mem_ff[thr_idx] : '0;
            end
        end
    end

endmodule : cdf_top
`default_nettype wire

/* tb/cdf_top_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// Port-level checks; acceptance controls stay still while words are in flight.
module cdf_top_properties
    import cdf_pkg::*;
(
    // Clock and reset
    input wire logic              clk_sys_i,
    input wire logic              reset_i,
    // Sequencer
    input wire logic              gate_i,
    input wire logic              integrate_switch_o,
    input wire logic              discharge_switch_o,
    input wire logic              conv_start_o,
    input wire logic              keep_below_i,
    input wire logic              keep_ovf_i,
    // Threshold port
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic              reg_rd_i,
    input wire logic [WORD_W-1:0] reg_rdata_o,
    input wire logic              reg_rvalid_o,
    // Data memory side
    input wire logic              mem_wr_valid_o,
    input wire logic              mem_wr_ready_i,
    input wire logic [CH_W-1:0]   mem_wr_chan_o,
    input wire logic [WORD_W-1:0] mem_wr_data_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    property p_integ_rise; $rose(integrate_switch_o) |-> $past(gate_i); endproperty
    a_integ_rise: assert property (p_integ_rise) else $error("switch closed without window");
    property p_integ_fall; integrate_switch_o && !gate_i |=> !integrate_switch_o; endproperty
    a_integ_fall: assert property (p_integ_fall) else $error("switch open late");
    property p_quiet; integrate_switch_o |-> !conv_start_o && !discharge_switch_o; endproperty
    a_quiet: assert property (p_quiet) else $error("conversion during window");
    property p_dis; $rose(discharge_switch_o) |-> discharge_switch_o [*8]; endproperty
    a_dis: assert property (p_dis) else $error("discharge too short");
    property p_start; conv_start_o |=> !conv_start_o; endproperty
    a_start: assert property (p_start) else $error("start longer than a pulse");
    property p_rd; reg_rd_i |=> reg_rvalid_o; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_rd_out;
        reg_rd_i && (reg_addr_i < THR_BASE || reg_addr_i > THR_LAST) |=> reg_rdata_o == 16'h0000;
    endproperty
    a_rd_out: assert property (p_rd_out) else $error("unmapped read not zero");
    property p_rd_bits; reg_rvalid_o |-> reg_rdata_o[15:9] == 7'h00; endproperty
    a_rd_bits: assert property (p_rd_bits) else $error("unused entry bits set");
    property p_hold;
        mem_wr_valid_o && !mem_wr_ready_i |=> mem_wr_valid_o && $stable(mem_wr_data_o) && $stable(mem_wr_chan_o);
    endproperty
    a_hold: assert property (p_hold) else $error("stalled word changed");
    property p_below; mem_wr_valid_o && !keep_below_i |-> !mem_wr_data_o[WORD_BELOW_BIT]; endproperty
    a_below: assert property (p_below) else $error("below word stored");
    property p_ovf; mem_wr_valid_o && !keep_ovf_i |-> !mem_wr_data_o[WORD_OVF_BIT]; endproperty
    a_ovf: assert property (p_ovf) else $error("overflow word stored");
    // Main scenarios reached.
    c_dis: cover property ($rose(discharge_switch_o));
    c_stall: cover property (mem_wr_valid_o && !mem_wr_ready_i);
    c_below: cover property (mem_wr_valid_o && mem_wr_data_o[WORD_BELOW_BIT]);
    c_ovf: cover property (mem_wr_valid_o && mem_wr_data_o[WORD_OVF_BIT]);
endmodule : cdf_top_properties
bind cdf_top cdf_top_properties chk_u (.clk_sys_i, .reset_i, .gate_i, .integrate_switch_o, .discharge_switch_o,
    .conv_start_o, .keep_below_i, .keep_ovf_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o,
    .mem_wr_valid_o, .mem_wr_ready_i, .mem_wr_chan_o, .mem_wr_data_o);
`default_nettype wire

/* tb/cdf_mem_sink.sv */
`timescale 1ns/1ps
`default_nettype none
// Data memory model: takes every word offered, and can stall to fill the buffer.
module cdf_mem_sink
    import cdf_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              reset_i,
    // Stall request from the bench
    input  wire logic              stall_i,
    // Write side
    input  wire logic              wr_valid_i,
    output logic                   wr_ready_o,
    input  wire logic [CH_W-1:0]   wr_chan_i,
    input  wire logic [WORD_W-1:0] wr_data_i
);
    logic [1:0]  phase_ff;
    cdf_result_s got_q[$];

    initial begin
        phase_ff = 2'h0;
        wr_ready_o = 1'b0;
    end
    // Ready moves at the falling edge; a stalled sink takes one cycle in four so the buffer fills.
    always @(negedge clk_sys_i) begin
        phase_ff <= phase_ff + 2'h1;
        wr_ready_o <= !stall_i || (phase_ff == 2'h3);
    end
    // A word is taken at the rising edge where valid and ready are both high.
    always @(posedge clk_sys_i) begin
        if (reset_i === 1'b0 && wr_valid_i === 1'b1 && wr_ready_o) begin
            got_q.push_back({wr_chan_i, wr_data_i});
        end
    end
endmodule : cdf_mem_sink
`default_nettype wire

/* tb/cdf_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
// Register and event tests of the acceptance stage.
module cdf_top_test
    import cdf_pkg::*;
;
    logic clk_sys_i = 1'b0, reset_i = 1'b1, gate_i = 1'b0, conv_done_i = 1'b0, stall = 1'b0;
    logic conv_a_ovf_i = 1'b0, conv_b_ovf_i = 1'b0, slide_en_i = 1'b0, thr_scale_i = 1'b0;
    logic keep_below_i = 1'b0, keep_ovf_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, mem_wr_ready_i;
    logic [RES_W-1:0] conv_a_data_i = 12'h000, conv_b_data_i = 12'h000;
    logic [ADDR_W-1:0] reg_addr_i = 16'h0000;
    logic [WORD_W-1:0] reg_wdata_i = 16'h0000, reg_rdata_o, d, mem_wr_data_o, thr_tab[NUM_CH];
    logic integrate_switch_o, discharge_switch_o, busy_o, conv_start_o, conv_range_o, slide_add_o;
    logic reg_rvalid_o, mem_wr_valid_o;
    logic [PAIR_W-1:0] conv_pair_o;
    logic [OFS_W-1:0] slide_offset_o;
    logic [CH_W-1:0] mem_wr_chan_o;
    cdf_result_s exp_q[$];
    int errors = 0, comparisons = 0, n_start, n_dis;
    cdf_top dut_u (.clk_sys_i, .reset_i, .gate_i, .integrate_switch_o, .discharge_switch_o, .busy_o,
        .conv_start_o, .conv_pair_o, .conv_range_o, .conv_done_i, .conv_a_data_i, .conv_a_ovf_i, .conv_b_data_i,
        .conv_b_ovf_i, .slide_en_i, .slide_add_o, .slide_offset_o, .thr_scale_i, .keep_below_i, .keep_ovf_i,
        .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .mem_wr_valid_o,
        .mem_wr_ready_i, .mem_wr_chan_o, .mem_wr_data_o);
    cdf_mem_sink sink_u (.clk_sys_i, .reset_i, .stall_i(stall), .wr_valid_i(mem_wr_valid_o),
        .wr_ready_o(mem_wr_ready_i), .wr_chan_i(mem_wr_chan_o), .wr_data_i(mem_wr_data_o));
    // Free-running 20 MHz clock.
    always #25 clk_sys_i = ~clk_sys_i;
    // Starts and discharge cycles are counted per event.
    always @(posedge clk_sys_i) begin
        n_start += int'(conv_start_o === 1'b1);
        n_dis += int'(discharge_switch_o === 1'b1);
    end
    // Analog level per channel; fine codes 3840 and 3841 probe the sliding limit.
    function automatic logic [RES_W-1:0] val(input int ch, input logic r);
        if (ch == 14 && !r) return 12'hf00;
        if (ch == 15 && !r) return 12'hf01;
        return 12'((ch + 1) * (r ? 2 : 16) - ch % 2);
    endfunction : val
    // Converter model: codes come three cycles after a start, offset included, then go stale.
    always @(negedge clk_sys_i) begin
        if (conv_start_o === 1'b1) begin
            repeat (2) @(negedge clk_sys_i);
            conv_a_data_i = val(conv_pair_o, conv_range_o) + (slide_add_o ? 12'(slide_offset_o) : 12'h000);
            conv_b_data_i = val(conv_pair_o + 8, conv_range_o) + (slide_add_o ? 12'(slide_offset_o) : 12'h000);
            {conv_a_ovf_i, conv_b_ovf_i} = {2{conv_pair_o == 3'h3}};
            conv_done_i = 1'b1;
            @(negedge clk_sys_i);
            conv_done_i = 1'b0;
            conv_a_data_i = ~conv_a_data_i;
            conv_b_data_i = ~conv_b_data_i;
        end
    end
    task automatic chk(input logic [RESULT_W-1:0] g, input logic [RESULT_W-1:0] e);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic chk_n(input int g, input int e);
        comparisons++;
        if (g != e) begin
            errors++;
            $display("CHECK FAILED %0t count %0d expected %0d", $time, g, e);
        end
    endtask : chk_n
    task automatic stop_test();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test
    // Strobes rise at a falling edge and drop one cycle later; a spare cycle keeps calls apart.
    task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] v);
        reg_addr_i = a;
        reg_wdata_i = v;
        reg_wr_i = 1'b1;
        @(negedge clk_sys_i);
        reg_wr_i = 1'b0;
        @(negedge clk_sys_i);
    endtask : reg_write
    task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [WORD_W-1:0] v);
        int i;
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge clk_sys_i);
        reg_rd_i = 1'b0;
        for (i = 0; i < 4 && reg_rvalid_o !== 1'b1; i++) @(negedge clk_sys_i);
        if (i == 4) begin
            chk_n(i, 0);
            stop_test();
        end
        v = reg_rdata_o;
        @(negedge clk_sys_i);
    endtask : reg_read
    // One event under given controls; expected words come from thresholds and flags.
    task automatic run_ev(input logic sc, input logic kb, input logic ko, input logic sl, input logic st);
        int ch, i;
        logic [RES_W-1:0] v;
        logic ov, bl, r;
        thr_scale_i = sc;
        keep_below_i = kb;
        keep_ovf_i = ko;
        slide_en_i = sl;
        stall = st;
        n_start = 0;
        n_dis = 0;
        sink_u.got_q.delete();
        exp_q.delete();
        for (int s = 0; s < 16; s++) begin
            for (int k = 0; k < 2; k++) begin
                ch = s % 8 + 8 * k;
                r = (s >= 8);
                v = val(ch, r);
                ov = (ch % 8 == 3) || (sl && v > 12'd3840);
                bl = sc ? (v[11:9] == 3'h0 && v[8:1] < thr_tab[ch][7:0]) : (v[11:4] < thr_tab[ch][7:0]);
                if (!thr_tab[ch][8] && !(ov && !ko) && !(bl && !kb)) begin
                    exp_q.push_back({4'(ch), 1'b0, r, bl, ov, v});
                end
            end
        end
        gate_i = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        gate_i = 1'b0;
        repeat (20) @(negedge clk_sys_i);
        gate_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        gate_i = 1'b0;
        for (i = 0; i < 3000 && (busy_o !== 1'b0 || mem_wr_valid_o !== 1'b0); i++) @(negedge clk_sys_i);
        if (i == 3000) begin
            errors++;
            $display("CHECK FAILED %0t event did not finish", $time);
            stop_test();
        end
        repeat (3) @(negedge clk_sys_i);
        chk_n(n_start, 16);
        chk_n(n_dis, DISCHARGE_CYC);
        chk_n(sink_u.got_q.size(), exp_q.size());
        for (i = 0; i < exp_q.size() && i < sink_u.got_q.size(); i++) begin
            chk(sink_u.got_q[i], exp_q[i]);
        end
        $display("event test done scale %0d below %0d ovf %0d slide %0d", sc, kb, ko, sl);
    endtask : run_ev
    // Main sequence.
    initial begin
        repeat (3) @(negedge clk_sys_i);
        reset_i = 1'b0;
        for (int i = 0; i < 16; i++) begin
            thr_tab[i] = {7'h00, i == 5, 8'(i + 1)};
            reg_read(THR_BASE + 16'(4 * i), d);
            chk({4'h0, d}, 20'h00000);
            reg_write(THR_BASE + 16'(4 * i), 16'hfe00 | thr_tab[i]);
        end
        reg_write(16'h10c0, 16'h00ff);
        reg_read(16'h10c0, d);
        chk({4'h0, d}, 20'h00000);
        reset_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        reset_i = 1'b0;
        for (int i = 0; i < 16; i++) begin
            reg_read(THR_BASE + 16'(4 * i), d);
            chk({4'h0, d}, {4'h0, thr_tab[i]});
        end
        $display("threshold memory test done");
        run_ev(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        run_ev(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
        run_ev(1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
        run_ev(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
        stop_test();
    end
endmodule : cdf_top_test
`default_nettype wire
